// file: rtl/uec_defines.svh
// register indices, field positions, reset values of the error-irq / data-port block
// assumes an avalon-mm byte address; byte address is four times the index
`ifndef UEC_DEFINES_SVH
`define UEC_DEFINES_SVH

// register indices
`define UEC_IDX_CTRL3      4'h6
`define UEC_IDX_DATA       4'h7
`define UEC_IDX_STAT       4'h8
`define UEC_IDX_MASK       4'h9

// serial_control_three fields
`define UEC_C3_RX_NINTH    7
`define UEC_C3_TX_NINTH    6
`define UEC_C3_TX_DIR      5
`define UEC_C3_TX_INV      4
`define UEC_C3_OVR_EN      3
`define UEC_C3_NOISE_EN    2
`define UEC_C3_FRAME_EN    1
`define UEC_C3_PARITY_EN   0

// widths and reset values
`define UEC_NUM_ERR        4
`define UEC_DATA_W         8
`define UEC_CTRL3_RST      7'h00
`define UEC_STAT_RST       4'h0
`define UEC_MASK_RST       4'h0
`define UEC_TX_RST         8'h00

`endif

// file: rtl/uec_pkg.sv
// types shared by the error-irq / data-port block and its bench
// assumes flags arrive as levels from receive logic on the same clock
package uec_pkg;

   // error flags, in the same bit order as their enables
   typedef struct packed
   {
      logic overrun;
      logic noise;
      logic framing;
      logic parity;
   } uec_err_t;

   // word handed to the transmit shifter
   typedef struct packed
   {
      logic       ninth;
      logic [7:0] data;
   } uec_tx_t;

endpackage

// file: rtl/uec_data_port.sv
// error interrupt enables, shared receive/transmit data port, sticky error status
// assumes flags, receive buffer and ninth bit come from logic on this clock
//
// Operation
// - overrun enable gates overrun flag to request
// - noise enable gates noise flag to request
// - framing enable gates framing flag to request
// - parity enable gates parity flag to request
// - data read returns the receive buffer
// - data write loads transmit buffer only
// - data reads are flag clearing steps
// - data port eight bits, bit for bit
// - ninth transmit bit joins data on write
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "uec_defines.svh"

module uec_data_port
(
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     resetn,
   // avalon-mm slave
   input  wire logic [5:0]               address,
   input  wire logic                     read,
   input  wire logic                     write,
   input  wire logic [3:0]               byteenable,
   input  wire logic [31:0]              writedata,
   output logic      [31:0]              readdata,
   output logic                          waitrequest,
   // receive side
   input  wire uec_pkg::uec_err_t        errFlags,
   input  wire logic [7:0]               rxBuffer,
   input  wire logic                     rxNinthBit,
   // transmit side
   output uec_pkg::uec_tx_t              txWord,
   output logic                          txLoad,
   output logic                          txDir,
   output logic                          txInvert,
   // flag clearing step
   output logic                          dataReadStep,
   // interrupts
   output logic                          errIrq,
   output logic                          irq
);
   import uec_pkg::*;

   logic [6:0]                 ctrl3_r;
   logic [31:0]                readData_r;
   logic                       waitReq_r;
   uec_tx_t                    txWord_r;
   logic                       txLoad_r;
   logic                       dataRead_r;
   logic                       errIrq_r;
   logic                       irq_r;
   logic [`UEC_NUM_ERR-1:0]    stat_r;
   logic [`UEC_NUM_ERR-1:0]    mask_r;
   logic [`UEC_NUM_ERR-1:0]    flagPrev_r;
   logic [`UEC_NUM_ERR-1:0]    flagVec;
   logic [`UEC_NUM_ERR-1:0]    errEn;
   logic [`UEC_NUM_ERR-1:0]    flagRise;
   logic [`UEC_NUM_ERR-1:0]    statClr;
   logic [`UEC_NUM_ERR-1:0]    stat_nxt;
   logic [3:0]                 regIdx;
   logic                       aligned;
   logic                       request;
   logic                       accept;
   logic                       wrLow;

   assign flagVec  = errFlags;
   assign errEn    = ctrl3_r[`UEC_C3_OVR_EN:`UEC_C3_PARITY_EN];
   assign regIdx   = address[5:2];
   assign aligned  = (address[1:0] == 2'h0);
   assign request  = read | write;
   // writes and the data-read step act only at the edge where the master sees waitrequest low; the read mux loads one edge earlier
   assign accept   = request & ~waitReq_r;
   assign wrLow    = accept & write & aligned & byteenable[0];
   assign flagRise = flagVec & ~flagPrev_r;

   // one wait cycle per access, so read data is registered and the output stays a flop
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         waitReq_r <= 1'b1;
      else if (request & waitReq_r)
         waitReq_r <= 1'b0;
      else
         waitReq_r <= 1'b1;
   end

   // read mux, loaded one edge before the access completes
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         readData_r <= 32'h0;
      else if (read & waitReq_r)
      begin
         readData_r <= 32'h0;
         if (aligned)
         begin
            unique case (regIdx)
               `UEC_IDX_CTRL3:
                  readData_r[7:0] <= {rxNinthBit, ctrl3_r};
               `UEC_IDX_DATA:
                  readData_r[`UEC_DATA_W-1:0] <= rxBuffer;
               `UEC_IDX_STAT:
                  readData_r[`UEC_NUM_ERR-1:0] <= stat_r;
               `UEC_IDX_MASK:
                  readData_r[`UEC_NUM_ERR-1:0] <= mask_r;
               default:
                  readData_r <= 32'h0;
            endcase
         end
      end
   end

   // control three: enables, ninth tx bit, pin direction and inversion
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         ctrl3_r <= `UEC_CTRL3_RST;
      else if (wrLow && regIdx == `UEC_IDX_CTRL3)
         ctrl3_r <= writedata[6:0];
   end

   // write loads word and pulses txLoad for one cycle
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         txWord_r <= '{ninth: 1'b0, data: `UEC_TX_RST};
         txLoad_r <= 1'b0;
      end
      else
      begin
         txLoad_r <= wrLow && regIdx == `UEC_IDX_DATA;
         if (wrLow && regIdx == `UEC_IDX_DATA)
            txWord_r <= '{ninth: ctrl3_r[`UEC_C3_TX_NINTH], data: writedata[7:0]};
      end
   end

   // completed data read is a step of flag clearing
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         dataRead_r <= 1'b0;
      else
         dataRead_r <= accept & read & aligned & (regIdx == `UEC_IDX_DATA);
   end

   // enabled flags ored to one request
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         errIrq_r <= 1'b0;
      else
         errIrq_r <= |(flagVec & errEn);
   end

   // edge memory so a flag that stays high sets its sticky bit once
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         flagPrev_r <= '0;
      else
         flagPrev_r <= flagVec;
   end

   // sticky status, write one to clear; a new rise in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < `UEC_NUM_ERR; gi++)
      begin : g_stat
         assign statClr[gi]  = wrLow && regIdx == `UEC_IDX_STAT && writedata[gi];
         assign stat_nxt[gi] = flagRise[gi] | (stat_r[gi] & ~statClr[gi]);
      end
   endgenerate

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         stat_r <= `UEC_STAT_RST;
      else
         stat_r <= stat_nxt;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         mask_r <= `UEC_MASK_RST;
      else if (wrLow && regIdx == `UEC_IDX_MASK)
         mask_r <= writedata[`UEC_NUM_ERR-1:0];
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         irq_r <= 1'b0;
      else
         irq_r <= |(stat_r & mask_r);
   end

   assign readdata     = readData_r;
   assign waitrequest  = waitReq_r;
   assign txWord       = txWord_r;
   assign txLoad       = txLoad_r;
   assign txDir        = ctrl3_r[`UEC_C3_TX_DIR];
   assign txInvert     = ctrl3_r[`UEC_C3_TX_INV];
   assign dataReadStep = dataRead_r;
   assign errIrq       = errIrq_r;
   assign irq          = irq_r;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence s_dataReadReq;
      read && waitReq_r && aligned && regIdx == `UEC_IDX_DATA;
   endsequence

   sequence s_dataReadDone;
      !waitrequest && read;
   endsequence

   sequence s_dataWriteDone;
      !waitrequest && write && aligned && byteenable[0] && regIdx == `UEC_IDX_DATA;
   endsequence

   sequence s_ctrlReadReq;
      read && waitReq_r && aligned && regIdx == `UEC_IDX_CTRL3;
   endsequence

   sequence s_statReadReq;
      read && waitReq_r && aligned && regIdx == `UEC_IDX_STAT;
   endsequence

   a_overrun_gate: assert property (
      errFlags.overrun && ctrl3_r[`UEC_C3_OVR_EN] |=> errIrq)
      else $error("overrun enabled but no request");

   a_noise_gate: assert property (errFlags.noise && ctrl3_r[`UEC_C3_NOISE_EN] |=> errIrq)
      else $error("noise enabled but no request");

   a_framing_gate: assert property (errFlags.framing && errEn[1] |=> errIrq)
      else $error("framing enabled but no request");

   a_parity_gate: assert property (errFlags.parity && errEn[0] |=> errIrq)
      else $error("parity enabled but no request");

   a_err_irq_drop: assert property ((flagVec & errEn) == '0 |=> !errIrq)
      else $error("error request without enabled flag");

   a_rx_read_data: assert property (s_dataReadReq ##1 s_dataReadDone |->
      readdata[7:0] == $past(rxBuffer))
      else $error("data read did not return receive buffer");

   a_read_upper_zero: assert property (!waitrequest && read |-> readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");

   a_tx_write_load: assert property (s_dataWriteDone |=>
      txLoad && txWord.data == $past(writedata[7:0]) ##1 !txLoad)
      else $error("data write did not load transmit word once");

   a_ninth_join: assert property (s_dataWriteDone |=>
      txWord.ninth == $past(ctrl3_r[`UEC_C3_TX_NINTH]))
      else $error("ninth transmit bit not taken at write");

   a_read_step: assert property (s_dataReadReq ##1 s_dataReadDone |=> dataReadStep)
      else $error("data read gave no clearing step");

   a_sticky_irq: assert property (flagRise[3] && mask_r[3] |=> ##1 irq)
      else $error("masked-in overrun rise gave no interrupt");

   a_wait_answer: assert property (request && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait");

   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_read_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
      else $error("read data changed without a read");

   a_tx_hold: assert property (!(wrLow && regIdx == `UEC_IDX_DATA) |=> $stable(txWord))
      else $error("transmit word changed without a write");

   a_load_single: assert property (txLoad |=> !txLoad)
      else $error("transmit load longer than one cycle");

   a_load_cause: assert property (txLoad |-> $past(write) && !$past(waitrequest))
      else $error("transmit load without a completed write");

   a_step_single: assert property (dataReadStep |=> !dataReadStep)
      else $error("clearing step longer than one cycle");

   a_step_cause: assert property (dataReadStep |-> $past(read) && !$past(waitrequest))
      else $error("clearing step without a completed read");

   a_ctrl_read: assert property (s_ctrlReadReq |=>
      readdata[7:0] == {$past(rxNinthBit), $past(ctrl3_r)})
      else $error("control three read mismatch");

   a_ctrl_write: assert property (wrLow && regIdx == `UEC_IDX_CTRL3 |=>
      ctrl3_r == $past(writedata[6:0]))
      else $error("control three write lost");

   a_unaligned_skip: assert property (accept && write && !aligned |=>
      $stable(ctrl3_r) && $stable(mask_r) && $stable(txWord))
      else $error("unaligned write changed a register");

   a_stat_set: assert property (flagRise != '0 |=>
      (stat_r & $past(flagRise)) == $past(flagRise))
      else $error("status bit not set by flag rise");

   a_stat_clear: assert property (statClr != '0 |=>
      (stat_r & $past(statClr) & ~$past(flagRise)) == '0)
      else $error("status bit not cleared by write");

   a_stat_read: assert property (s_statReadReq |=>
      readdata[`UEC_NUM_ERR-1:0] == $past(stat_r))
      else $error("status read mismatch");

   a_irq_level: assert property ((stat_r & mask_r) != '0 |=> irq)
      else $error("unmasked status gave no interrupt");

   a_irq_drop: assert property ((stat_r & mask_r) == '0 |=> !irq)
      else $error("interrupt without unmasked status");

endmodule

// file: verif/uec_rx_model.sv
// far-side receive model: sticky error flags, receive byte and ninth bit
// assumes the bench pulses errSet and rxPush for one cycle each
`timescale 1ns/10ps
module uec_rx_model
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // bench stimulus
   input  wire logic [3:0] errSet,
   input  wire logic       rxPush,
   input  wire logic [8:0] rxIn,
   // from the block
   input  wire logic       dataReadStep,
   // to the block
   output uec_pkg::uec_err_t errFlags,
   output logic [7:0]      rxBuffer,
   output logic            rxNinthBit
);
   import uec_pkg::*;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         errFlags <= '0;
      else if (dataReadStep)
         errFlags <= '0;
      else
         errFlags <= errFlags | errSet;
   end

   // ninth bit and byte land together
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         {rxNinthBit, rxBuffer} <= 9'h000;
      else if (rxPush)
         {rxNinthBit, rxBuffer} <= rxIn;
   end
endmodule

// file: verif/uec_data_port_tb.sv
// bench for the error-irq / data-port block over avalon-mm
// assumes the far side is the receive model beside it
`timescale 1ns/10ps
module uec_data_port_tb;
   import uec_pkg::*;
   logic        clock = 0, resetn = 0, read = 0, write = 0, rxPush = 0;
   logic [5:0]  address = '0;
   logic [31:0] writedata = '0, readdata, rdv;
   logic [3:0]  errSet = '0;
   logic [3:0]  byteEn = 4'h1;
   logic [8:0]  rxIn = '0;
   logic        waitrequest, txLoad, txDir, txInvert, dataReadStep, errIrq, irq, rxNinthBit;
   logic [7:0]  rxBuffer;
   uec_err_t    errFlags;
   uec_tx_t     txWord;
   int          errTotal = 0, nChecks = 0;

   always #5 clock = ~clock;

   uec_data_port uec_data_port_inst (.clock(clock), .resetn(resetn), .address(address),
      .read(read), .write(write), .byteenable(byteEn), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .errFlags(errFlags),
      .rxBuffer(rxBuffer), .rxNinthBit(rxNinthBit), .txWord(txWord), .txLoad(txLoad),
      .txDir(txDir), .txInvert(txInvert), .dataReadStep(dataReadStep),
      .errIrq(errIrq), .irq(irq));

   uec_rx_model uec_rx_model_inst (.clock(clock), .resetn(resetn), .errSet(errSet),
      .rxPush(rxPush), .rxIn(rxIn), .dataReadStep(dataReadStep), .errFlags(errFlags),
      .rxBuffer(rxBuffer), .rxNinthBit(rxNinthBit));

   task automatic close_out();
      if (errTotal == 0 && nChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      writedata <= {24'h000000, wd};
      read <= !wr;
      write <= wr;
      @(posedge clock);
      // value before this edge, which is what the block samples here
      while (waitrequest !== 1'b0)
      begin
         n++;
         if (n > 20)
         begin
            errTotal++;
            close_out();
         end
         @(posedge clock);
      end
      rdv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rdv, exp);
   endtask

   task automatic push(input logic [3:0] e, input logic p, input logic [8:0] v);
      @(posedge clock);
      errSet <= e;
      rxPush <= p;
      rxIn <= v;
      @(posedge clock);
      errSet <= 4'h0;
      rxPush <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask

   initial
   begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rdchk(6'h18, 32'h0);
      rdchk(6'h20, 32'h0);
      rdchk(6'h24, 32'h0);
      push(4'h0, 1'b1, 9'h13c);
      bus(1'b1, 6'h18, 8'h40);
      bus(1'b1, 6'h1c, 8'ha5);
      tick(1);
      chk(txLoad, 32'h1);
      chk(txWord, 32'h1a5);
      rdchk(6'h18, 32'hc0);
      rdchk(6'h1c, 32'h3c);
      rdchk(6'h3c, 32'h0);
      bus(1'b1, 6'h19, 8'h0f);
      rdchk(6'h18, 32'hc0);
      // a write without its low byte lane is dropped
      @(posedge clock);
      byteEn <= 4'h0;
      bus(1'b1, 6'h18, 8'h0f);
      byteEn <= 4'h1;
      rdchk(6'h18, 32'hc0);
      bus(1'b1, 6'h18, 8'h30);
      tick(1);
      chk({txDir, txInvert}, 32'h3);
      bus(1'b1, 6'h1c, 8'h5a);
      tick(1);
      chk(txWord, 32'h05a);
      // one enable at a time, the other three flags must stay silent
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, 6'h18, 8'h01 << i);
         push(~(4'h1 << i), 1'b0, 9'h000);
         tick(4);
         chk(errIrq, 32'h0);
         push(4'hf, 1'b0, 9'h000);
         tick(4);
         chk(errIrq, 32'h1);
         rdchk(6'h1c, 32'h3c);
         tick(1);
         chk(dataReadStep, 32'h1);
         tick(3);
         chk(errIrq, 32'h0);
      end
      rdchk(6'h20, 32'hf);
      chk(irq, 32'h0);
      bus(1'b1, 6'h24, 8'h02);
      tick(3);
      chk(irq, 32'h1);
      bus(1'b1, 6'h20, 8'h02);
      tick(3);
      chk(irq, 32'h0);
      rdchk(6'h20, 32'hd);
      close_out();
   end
endmodule
